// ### vdec_core.sv
// decoder for vector arithmetic instructions, registered output.
// assumes inputs come from issue logic on clk, scalar values already read.
`timescale 1ns/100ps
module vdec_core (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [1:0] selected_element_width,
    input wire logic [2:0] dyn_round_mode,
    input wire logic floats_in_int_regs,
    input wire logic [63:0] int_reg_value,
    input wire logic [63:0] float_reg_value,
    output vdec_pkg::decoded_s decoded,
    output logic illegal_instr
);
    logic [5:0] f6;
    logic [2:0] cat_raw;
    logic [4:0] src1;
    logic is_vec;
    logic is_fp;
    logic [63:0] imm_ext;
    logic [63:0] int_sc;
    logic [63:0] fp_sc;
    logic boxed;
    logic widen;
    logic narrow;
    logic wide_first;
    logic madd;
    logic fp_bad;
    logic frm_bad;
    vdec_pkg::decoded_s d;
    vdec_pkg::decoded_s decoded_q;

    assign f6 = instr[vdec_pkg::FUNCT6_LSB +: 6];
    assign cat_raw = instr[vdec_pkg::CAT_LSB +: 3];
    assign src1 = instr[vdec_pkg::SRC1_LSB +: 5];
    // RQ1 opcode match
    assign is_vec = instr[vdec_pkg::OPC_LSB +: 7]
                    == vdec_pkg::VECTOR_MAJOR_OPCODE;
    assign is_fp = cat_raw == 3'h1 || cat_raw == 3'h5;

    // RQ6 RQ7 immediate extension, unsigned for shift-like ops
    always_comb begin
        imm_ext = {{59{src1[4]}}, src1};
        if (f6 >= vdec_pkg::F6_UIMM_LO && f6 <= vdec_pkg::F6_UIMM_HI) begin
            imm_ext = {59'h0, src1};
        end
        case (selected_element_width)
            vdec_pkg::EW8: imm_ext = {56'h0, imm_ext[7:0]};
            vdec_pkg::EW16: imm_ext = {48'h0, imm_ext[15:0]};
            vdec_pkg::EW32: imm_ext = {32'h0, imm_ext[31:0]};
            default: imm_ext = imm_ext;
        endcase
    end

    // RQ8 RQ11 integer scalar keeps low element-width bits
    always_comb begin
        case (selected_element_width)
            vdec_pkg::EW8: int_sc = {56'h0, int_reg_value[7:0]};
            vdec_pkg::EW16: int_sc = {48'h0, int_reg_value[15:0]};
            vdec_pkg::EW32: int_sc = {32'h0, int_reg_value[31:0]};
            default: int_sc = int_reg_value;
        endcase
    end

    // RQ9 box check against all ones above the element
    always_comb begin
        case (selected_element_width)
            vdec_pkg::EW16: begin
                boxed = &float_reg_value[63:16];
                fp_sc = boxed ? {48'h0, float_reg_value[15:0]}
                              : vdec_pkg::CANON_NAN_H;
            end
            vdec_pkg::EW32: begin
                boxed = &float_reg_value[63:32];
                fp_sc = boxed ? {32'h0, float_reg_value[31:0]}
                              : vdec_pkg::CANON_NAN_S;
            end
            default: begin
                boxed = 1'b1;
                fp_sc = float_reg_value;
            end
        endcase
    end

    // RQ10 unsupported float width
    assign fp_bad = !vdec_pkg::FP_SUPPORTED[selected_element_width];
    // RQ4 invalid dynamic rounding mode
    assign frm_bad = dyn_round_mode > vdec_pkg::FRM_MAX_VALID;
    // RQ15 RQ16 widening group, w-variants take a wide first source
    assign widen = f6 >= vdec_pkg::F6_WADDU && f6 <= vdec_pkg::F6_WSUBW
                   && (cat_raw == 3'h2 || cat_raw == 3'h6);
    assign wide_first = widen && f6 >= vdec_pkg::F6_WIDE_W_BIT;
    // RQ17 RQ18 narrowing and mask compares
    assign narrow = (cat_raw == 3'h0 || cat_raw == 3'h3 || cat_raw == 3'h4)
                    && ((f6 >= vdec_pkg::F6_NARROW_LO
                         && f6 <= vdec_pkg::F6_NARROW_HI)
                        || (f6 >= vdec_pkg::F6_CMP_LO
                            && f6 <= vdec_pkg::F6_CMP_HI));
    // RQ14 multiply-add group
    assign madd = (cat_raw == 3'h2 || cat_raw == 3'h6 || is_fp)
                  && f6 >= vdec_pkg::F6_MADD_LO && f6 <= vdec_pkg::F6_MADD_HI;

    always_comb begin
        d = '0;
        d.valid = instr_valid && is_vec;
        // RQ2 category decode
        d.category = vdec_pkg::category_e'(cat_raw);
        // RQ12 mask enable low means masked
        d.masked = !instr[vdec_pkg::MASK_BIT];
        // RQ5 RQ13 operand order
        d.first_vreg = instr[vdec_pkg::SRC2_LSB +: 5];
        d.second_vreg = src1;
        d.dest_vreg = instr[vdec_pkg::DST_LSB +: 5];
        d.is_float = is_fp;
        // RQ4 dynamic rounding
        d.round_mode = dyn_round_mode;
        // RQ3 signedness: odd-low-bit widening ops are signed
        d.is_signed = widen ? f6[0] : 1'b1;
        // RQ19 single-width integer ops wrap
        d.wraps = !is_fp && !widen;
        d.dest_ew = selected_element_width;
        d.first_src_ew = selected_element_width;
        d.second_src_ew = selected_element_width;
        if (widen) begin
            d.dest_ew = selected_element_width + 2'h1;
            d.dest_mul_double = 1'b1;
            if (wide_first) begin
                d.first_src_ew = selected_element_width + 2'h1;
            end
        end
        if (narrow) begin
            d.first_src_ew = selected_element_width + 2'h1;
        end
        if (madd) begin
            d.madd_overwrite_addend = !f6[0];
            d.madd_overwrite_product = f6[0];
        end
        // RQ20 single-width add, sub, reverse sub
        d.alu_op = vdec_pkg::ALU_OTHER;
        if (cat_raw == 3'h0 || cat_raw == 3'h3 || cat_raw == 3'h4) begin
            case (f6)
                vdec_pkg::F6_ADD: d.alu_op = vdec_pkg::ALU_ADD;
                vdec_pkg::F6_SUB: d.alu_op = cat_raw == 3'h3
                    ? vdec_pkg::ALU_OTHER : vdec_pkg::ALU_SUB;
                vdec_pkg::F6_RSUB: d.alu_op = cat_raw == 3'h0
                    ? vdec_pkg::ALU_OTHER : vdec_pkg::ALU_RSUB;
                default: d.alu_op = vdec_pkg::ALU_OTHER;
            endcase
        end
        case (cat_raw)
            // RQ13 scalar is second operand except in multiply-add
            3'h3: begin
                d.first_is_scalar = madd;
                d.scalar_operand = imm_ext;
            end
            3'h4, 3'h6, 3'h7: begin
                d.first_is_scalar = madd;
                d.scalar_operand = int_sc;
            end
            3'h5: begin
                d.first_is_scalar = madd;
                // RQ11 integer-register floats
                d.scalar_operand = floats_in_int_regs ? int_sc : fp_sc;
            end
            default: d.first_is_scalar = 1'b0;
        endcase
        // RQ21 reserved float width or rounding and widening at EW64 raise illegal; narrowing at EW64 is never flagged
        d.illegal = d.valid && ((is_fp && (fp_bad || frm_bad))
                    || (widen && selected_element_width == vdec_pkg::EW64)
                    || (narrow && selected_element_width == vdec_pkg::EW64
                        && f6 < vdec_pkg::F6_CMP_LO));
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            decoded_q <= '0;
        end else begin
            decoded_q <= d;
        end
    end

    assign decoded = decoded_q;
    assign illegal_instr = decoded_q.illegal;

    // RQ1
    a_opcode_gate: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && !is_vec |=> !decoded.valid) else $error("bad valid");
    // RQ12
    a_mask_follow: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && is_vec |=> decoded.masked == !$past(instr[25]))
        else $error("mask wrong");
    // RQ9
    a_nan_subst: assert property (@(posedge clk) disable iff (sys_rst)
        cat_raw == 3'h5 && !floats_in_int_regs && !boxed
        && selected_element_width == vdec_pkg::EW32
        |=> decoded.scalar_operand == vdec_pkg::CANON_NAN_S)
        else $error("nan missing");
    // RQ4
    a_frm_illegal: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && is_vec && is_fp && frm_bad |=> illegal_instr)
        else $error("frm not flagged");
    // RQ10
    a_fp_width: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && is_vec && is_fp
        && selected_element_width == vdec_pkg::EW8 |=> illegal_instr)
        else $error("fp8 not flagged");
    // RQ15
    a_widen_dest: assert property (@(posedge clk) disable iff (sys_rst)
        widen |=> decoded.dest_mul_double
        && decoded.dest_ew == $past(selected_element_width) + 2'h1)
        else $error("widen width");
    // RQ5
    a_vv_order: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> decoded.first_vreg == $past(instr[24:20]))
        else $error("order wrong");
    // RQ6
    a_imm_sign: assert property (@(posedge clk) disable iff (sys_rst)
        cat_raw == 3'h3 && src1 == 5'h1F && f6 == vdec_pkg::F6_ADD
        && selected_element_width == vdec_pkg::EW64
        |=> decoded.scalar_operand == 64'hFFFF_FFFF_FFFF_FFFF)
        else $error("imm ext");
endmodule

// ### vdec_pkg.sv
// package for the vector arithmetic format decoder: field positions,
// category codes, opcode, widths and the decoded-instruction carrier.
// assumes a 32-bit instruction word and 64-bit scalar registers.
package vdec_pkg;

    localparam logic [6:0] VECTOR_MAJOR_OPCODE = 7'h57;
    localparam int OPC_LSB = 0;
    localparam int DST_LSB = 7;
    localparam int CAT_LSB = 12;
    localparam int SRC1_LSB = 15;
    localparam int SRC2_LSB = 20;
    localparam int MASK_BIT = 25;
    localparam int FUNCT6_LSB = 26;
    localparam int XREG_W = 64;
    localparam int FREG_W = 64;
    localparam int ELEM_W = 64;

    // element width encodings (8 << code)
    localparam logic [1:0] EW8 = 2'h0;
    localparam logic [1:0] EW16 = 2'h1;
    localparam logic [1:0] EW32 = 2'h2;
    localparam logic [1:0] EW64 = 2'h3;

    // float formats supported: 16, 32, 64 bits
    localparam logic [3:0] FP_SUPPORTED = 4'hE;

    localparam logic [2:0] FRM_MAX_VALID = 3'h4;
    localparam logic [2:0] FRM_DYN = 3'h7;

    // op codes (funct6) for the single-width add/sub group and others
    localparam logic [5:0] F6_ADD = 6'h00;
    localparam logic [5:0] F6_SUB = 6'h02;
    localparam logic [5:0] F6_RSUB = 6'h03;
    localparam logic [5:0] F6_WADDU = 6'h30;
    localparam logic [5:0] F6_WSUBW = 6'h37;
    localparam logic [5:0] F6_WIDE_W_BIT = 6'h34;
    localparam logic [5:0] F6_NARROW_LO = 6'h2C;
    localparam logic [5:0] F6_NARROW_HI = 6'h2F;
    localparam logic [5:0] F6_CMP_LO = 6'h18;
    localparam logic [5:0] F6_CMP_HI = 6'h1F;
    localparam logic [5:0] F6_MADD_LO = 6'h28;
    localparam logic [5:0] F6_MADD_HI = 6'h2F;
    localparam logic [5:0] F6_UIMM_LO = 6'h0C;
    localparam logic [5:0] F6_UIMM_HI = 6'h0E;

    localparam logic [63:0] CANON_NAN_H = 64'h0000_0000_0000_7E00;
    localparam logic [63:0] CANON_NAN_S = 64'h0000_0000_7FC0_0000;
    localparam logic [63:0] CANON_NAN_D = 64'h7FF8_0000_0000_0000;

    typedef enum logic [2:0] {
        INT_VEC_VEC_CATEGORY,
        FLOAT_VEC_VEC_CATEGORY,
        MISC_VEC_VEC_CATEGORY,
        INT_VEC_IMM_CATEGORY,
        INT_VEC_SCALAR_CATEGORY,
        FLOAT_VEC_SCALAR_CATEGORY,
        MISC_VEC_SCALAR_CATEGORY,
        CONFIGURATION_CATEGORY
    } category_e;

    typedef enum logic [1:0] {
        ALU_ADD,
        ALU_SUB,
        ALU_RSUB,
        ALU_OTHER
    } alu_op_e;

    typedef struct packed {
        logic valid;
        logic illegal;
        category_e category;
        alu_op_e alu_op;
        logic is_signed;
        logic masked;
        logic [4:0] first_vreg;
        logic [4:0] second_vreg;
        logic [4:0] dest_vreg;
        logic first_is_scalar;
        logic [63:0] scalar_operand;
        logic is_float;
        logic [2:0] round_mode;
        logic madd_overwrite_addend;
        logic madd_overwrite_product;
        logic [1:0] dest_ew;
        logic dest_mul_double;
        logic [1:0] first_src_ew;
        logic [1:0] second_src_ew;
        logic wraps;
    } decoded_s;

endpackage

// ### vector_arith_format_decoder.sv
// decoder for vector arithmetic instructions: category, operand choice,
// scalar adaptation, masking and width rules; registered result.
// assumes instruction and scalar register values arrive from logic on clk.
// Function
// RQ1 - recognise vector arithmetic by the vector major opcode value
// RQ2 - three-bit category field chooses the operand kind, eight codes
// RQ3 - integer ops are signed or unsigned by opcode; only widening ops take it from the opcode, all others are marked signed
// RQ4 - float ops use dynamic rounding; invalid mode is reserved always
// RQ5 - vector-vector: first operand from second-source, second from first
// RQ6 - five-bit immediate sign-extended to element width by default
// RQ7 - unsigned-immediate instructions zero-extend the five-bit immediate
// RQ8 - integer scalar truncated or sign-extended to element width
// RQ9 - float scalar uses low bits if boxed, else canonical NaN
// RQ10 - unsupported float element width is a reserved encoding
// RQ11 - floats in integer registers use integer scalar rule, no box check
// RQ12 - masked or unmasked per mask-enable bit
// RQ13 - binary ops: second-source vector first, scalar or immediate second
// RQ14 - multiply-add overwrites addend or multiplicand, two variants
// RQ15 - widening writes double element width and double group multiplier
// RQ16 - widening first source single or double width
// RQ17 - narrowing reads double-width second source, writes current width
// RQ18 - mask-writing compares handled as narrowing
// RQ19 - integer results wrap modulo element width
// RQ20 - add vv/vx/vi, sub vv/vx, reverse sub vector-scalar
// RQ21 - reserved encodings flagged illegal instead of executed; narrowing at element width 64 is not flagged
// the logic itself lives in module vdec_core

// ### issue_stage_model.sv
// issue stage stand-in: drives the instruction word and scalar operands.
// assumes the caller invokes its tasks at the falling edge of clk.
`timescale 1ns/100ps
module issue_stage_model (
    input wire logic clk,
    output logic instr_valid,
    output logic [31:0] instr,
    output logic [1:0] selected_element_width,
    output logic [2:0] dyn_round_mode,
    output logic floats_in_int_regs,
    output logic [63:0] int_reg_value,
    output logic [63:0] float_reg_value
);
    task automatic cfg(input logic [1:0] ew, input logic [2:0] rm,
                       input logic fin, input logic [63:0] xv, fv);
        selected_element_width = ew;
        dyn_round_mode = rm;
        floats_in_int_regs = fin;
        int_reg_value = xv;
        float_reg_value = fv;
    endtask

    // one word issued; the task returns one falling edge later and leaves it driven
    task automatic send(input logic [31:0] w);
        instr_valid = 1'b1;
        instr = w;
        @(negedge clk);
    endtask

    // nothing issued: word scrambled so a stale value is never reused
    task automatic idle();
        instr_valid = 1'b0;
        instr = ~instr;
        @(negedge clk);
    endtask
endmodule

// ### test_vector_arith_format_decoder.sv
// self-checking bench for the vector arithmetic format decoder.
// assumes vdec_pkg, vdec_core and issue_stage_model are compiled first.
`timescale 1ns/100ps
module test_vector_arith_format_decoder;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid, floats_in_int_regs, illegal_instr;
    logic [31:0] instr;
    logic [1:0] selected_element_width;
    logic [2:0] dyn_round_mode;
    logic [63:0] int_reg_value, float_reg_value;
    vdec_pkg::decoded_s decoded;
    int num_errors = 0;
    int checked = 0;
    logic [63:0] xv = 64'h8234_5678_9ABC_DEF0;
    logic [63:0] fv = 64'hFFFF_FFFF_4048_0000;
    logic [5:0] f6s [7] = '{6'h00, 6'h00, 6'h00, 6'h02, 6'h02, 6'h03, 6'h03};
    logic [2:0] f3s [7] = '{3'h0, 3'h4, 3'h3, 3'h0, 3'h4, 3'h4, 3'h3};
    int ops [7] = '{0, 0, 0, 1, 1, 2, 2};

    always #4 clk = ~clk;

    issue_stage_model issue_u (
        .clk(clk),
        .instr_valid(instr_valid),
        .instr(instr),
        .selected_element_width(selected_element_width),
        .dyn_round_mode(dyn_round_mode),
        .floats_in_int_regs(floats_in_int_regs),
        .int_reg_value(int_reg_value),
        .float_reg_value(float_reg_value)
    );

    vdec_core dut_u (
        .clk(clk),
        .sys_rst(sys_rst),
        .instr_valid(instr_valid),
        .instr(instr),
        .selected_element_width(selected_element_width),
        .dyn_round_mode(dyn_round_mode),
        .floats_in_int_regs(floats_in_int_regs),
        .int_reg_value(int_reg_value),
        .float_reg_value(float_reg_value),
        .decoded(decoded),
        .illegal_instr(illegal_instr)
    );

    function automatic logic [31:0] op(input logic [5:0] f6, input logic vm,
                                       input logic [4:0] a, b,
                                       input logic [2:0] f3);
        return {f6, vm, a, b, f3, 5'h09, vdec_pkg::VECTOR_MAJOR_OPCODE};
    endfunction

    task automatic cmp(input logic [63:0] got, exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic fscal(input logic [1:0] ew, input logic [63:0] f, exp);
        issue_u.cfg(ew, 3'h3, 1'b0, xv, f);
        issue_u.send(op(6'h00, 1'b1, 5'h5, 5'h2, 3'h5));
        cmp(decoded.scalar_operand, exp);
        cmp(64'(decoded.round_mode), 64'h3);
    endtask

    task automatic print_verdict();
        $display("errors %0d, comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (1500) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        int i;
        logic [63:0] m;
        issue_u.cfg(vdec_pkg::EW32, 3'h5, 1'b0, xv, fv);
        issue_u.send(op(6'h00, 1'b1, 5'h1, 5'h2, 3'h1));
        repeat (16) @(posedge clk);
        @(negedge clk);
        cmp(64'(|decoded), 64'h0);
        cmp(64'(illegal_instr), 64'h0);
        sys_rst = 1'b0;
        issue_u.cfg(vdec_pkg::EW32, 3'h0, 1'b0, xv, fv);
        issue_u.send(op(6'h00, 1'b1, 5'h3, 5'h7, 3'h0));
        cmp(64'(decoded.valid), 64'h1);
        cmp(64'(decoded.first_vreg), 64'h3);
        cmp(64'(decoded.second_vreg), 64'h7);
        cmp(64'(decoded.masked), 64'h0);
        cmp(64'(decoded.wraps), 64'h1);
        issue_u.send(op(6'h00, 1'b0, 5'h3, 5'h7, 3'h0));
        cmp(64'(decoded.masked), 64'h1);
        issue_u.send({25'h0, 7'h53});
        cmp(64'(decoded.valid), 64'h0);
        issue_u.idle();
        cmp(64'(decoded.valid), 64'h0);
        for (i = 0; i < 8; i++) begin
            issue_u.send(op(6'h00, 1'b1, 5'h1, 5'h2, 3'(i)));
            cmp(64'(decoded.category), 64'(i));
        end
        for (i = 0; i < 7; i++) begin
            issue_u.send(op(f6s[i], 1'b1, 5'h5, 5'h2, f3s[i]));
            cmp(64'(decoded.alu_op), 64'(ops[i]));
            cmp(64'(decoded.first_vreg), 64'h5);
        end
        for (i = 0; i < 4; i++) begin
            m = (i == 3) ? '1 : (64'h1 << (8 << i)) - 64'h1;
            issue_u.cfg(2'(i), 3'h0, 1'b0, xv, fv);
            issue_u.send(op(6'h00, 1'b1, 5'h5, 5'h2, 3'h4));
            cmp(decoded.scalar_operand, xv & m);
            cmp(64'(decoded.first_is_scalar), 64'h0);
            issue_u.send(op(6'h00, 1'b1, 5'h5, 5'h1E, 3'h3));
            cmp(decoded.scalar_operand, 64'hFFFF_FFFF_FFFF_FFFE & m);
            issue_u.send(op(vdec_pkg::F6_UIMM_LO, 1'b1, 5'h5, 5'h1E, 3'h3));
            cmp(decoded.scalar_operand, 64'h1E);
            issue_u.cfg(2'(i), 3'h0, 1'b1, xv, fv);
            issue_u.send(op(6'h00, 1'b1, 5'h5, 5'h2, 3'h5));
            if (i == 0)
                cmp(64'(illegal_instr), 64'h1);
            else
                cmp(decoded.scalar_operand, xv & m);
        end
        fscal(vdec_pkg::EW32, fv, 64'h4048_0000);
        fscal(vdec_pkg::EW32, 64'h1_4048_0000, vdec_pkg::CANON_NAN_S);
        fscal(vdec_pkg::EW16, fv, vdec_pkg::CANON_NAN_H);
        for (i = 0; i < 8; i++) begin
            issue_u.cfg(vdec_pkg::EW32, 3'(i), 1'b0, xv, fv);
            issue_u.send(op(6'h00, 1'b1, 5'h1, 5'h2, 3'h1));
            cmp(64'(illegal_instr), 64'(3'(i) > vdec_pkg::FRM_MAX_VALID));
            cmp(64'(decoded.illegal), 64'(i > 4));
            cmp(64'(decoded.is_float), 64'h1);
            issue_u.send(op(6'h00, 1'b1, 5'h1, 5'h2, 3'h0));
            cmp(64'(illegal_instr), 64'h0);
        end
        issue_u.cfg(vdec_pkg::EW16, 3'h0, 1'b0, xv, fv);
        issue_u.send(op(vdec_pkg::F6_WADDU, 1'b1, 5'h4, 5'h2, 3'h2));
        cmp(64'(decoded.dest_ew), 64'(vdec_pkg::EW32));
        cmp(64'(decoded.dest_mul_double), 64'h1);
        cmp(64'(decoded.first_src_ew), 64'(vdec_pkg::EW16));
        cmp(64'(decoded.is_signed), 64'h0);
        issue_u.send(op(vdec_pkg::F6_WSUBW, 1'b1, 5'h4, 5'h2, 3'h2));
        cmp(64'(decoded.is_signed), 64'h1);
        cmp(64'(decoded.first_src_ew), 64'(vdec_pkg::EW32));
        issue_u.send(op(vdec_pkg::F6_NARROW_LO, 1'b1, 5'h4, 5'h2, 3'h0));
        cmp(64'(decoded.first_src_ew), 64'(vdec_pkg::EW32));
        cmp(64'(decoded.second_src_ew), 64'(vdec_pkg::EW16));
        cmp(64'(decoded.dest_ew), 64'(vdec_pkg::EW16));
        issue_u.send(op(vdec_pkg::F6_CMP_LO, 1'b1, 5'h4, 5'h2, 3'h0));
        cmp(64'(decoded.first_src_ew), 64'(vdec_pkg::EW32));
        issue_u.send(op(6'h2C, 1'b1, 5'h4, 5'h2, 3'h2));
        cmp(64'(decoded.madd_overwrite_addend), 64'h1);
        cmp(64'(decoded.dest_vreg), 64'h9);
        cmp(64'(decoded.first_is_scalar), 64'h0);
        issue_u.send(op(6'h29, 1'b1, 5'h4, 5'h2, 3'h6));
        cmp(64'(decoded.madd_overwrite_product), 64'h1);
        cmp(64'(decoded.first_is_scalar), 64'h1);
        print_verdict();
    end
endmodule
